// ==== tb/psw_mac_model.sv ====
// Behavioural media access controller on the request and indicate ports
`default_nettype none

module psw_mac_model
	import psw_pkg::*;
(
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Indicate ports as driven
	input wire logic [PSW_BUS_W-1:0] first_ind,
	input wire logic first_oe,
	input wire logic [PSW_BUS_W-1:0] second_ind,
	input wire logic second_oe,
	// Request buses
	output logic [PSW_BUS_W-1:0] first_req_bus,
	output logic [PSW_BUS_W-1:0] second_req_bus,
	// Resolved indicate wires
	output logic [PSW_BUS_W-1:0] first_seen,
	output logic [PSW_BUS_W-1:0] second_seen
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] cnt_ff;
	logic [PSW_BUS_W-1:0] first_last_ff;
	logic [PSW_BUS_W-1:0] second_last_ff;

	// Request words differ every cycle so stale routing shows
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_ff <= 8'h00;
		end else begin
			cnt_ff <= cnt_ff + 8'h01;
		end
	end
	assign first_req_bus = {2'b01, cnt_ff};
	assign second_req_bus = {2'b10, ~cnt_ff};

	// Floating port shows the inverse of its value in the previous cycle
	always_ff @(posedge hclk) begin
		first_last_ff <= first_seen;
		second_last_ff <= second_seen;
	end
	assign first_seen = first_oe ? first_ind : ~first_last_ff;
	assign second_seen = second_oe ? second_ind : ~second_last_ff;
endmodule // psw_mac_model

`default_nettype wire

// ==== tb/tb.sv ====
// Self-checking bench for the configuration switch register bank
`default_nettype none

module tb;
	import psw_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int MAXH = 2;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0000_0000;
	logic [9:0] rx_bus = 10'h000;
	wire logic [31:0] hrdata, hrdata2;
	wire logic hreadyout, f_p, f_c, f_oe, s_p, s_c, s_oe, t_p, t_c, s_oe2;
	wire logic [7:0] f_d, s_d, t_d;
	wire logic [9:0] f_req, s_req, f_seen, s_seen;
	wire logic [9:0] f_bus = {f_p, f_c, f_d};
	wire logic [9:0] s_bus = {s_p, s_c, s_d};
	wire logic [9:0] t_bus = {t_p, t_c, t_d};
	logic [9:0] p [4];
	logic [9:0] q [4];
	logic [31:0] rd, rd2;
	logic [7:0] cfg, old;
	logic [1:0] a, b, c;
	int n;
	int num_errors = 0;
	int total_checks = 0;

	psw_switch_top #(.HAS_SECOND_IND(1'b1), .MAX_HALT_PAIRS(MAXH)) dut_u (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
		.hwdata(hwdata), .hreadyout(hreadyout), .hresp(), .hrdata(hrdata),
		.rx_bus(rx_bus), .first_req_bus(f_req), .second_req_bus(s_req),
		.first_ind_parity(f_p), .first_ind_control(f_c), .first_ind_data(f_d),
		.first_ind_oe(f_oe), .second_ind_parity(s_p),
		.second_ind_control(s_c), .second_ind_data(s_d), .second_ind_oe(s_oe),
		.tx_parity(t_p), .tx_control(t_c), .tx_data(t_d));

	psw_switch_top #(.HAS_SECOND_IND(1'b0), .MAX_HALT_PAIRS(MAXH)) dut2_u (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
		.hwdata(hwdata), .hreadyout(), .hresp(), .hrdata(hrdata2),
		.rx_bus(rx_bus), .first_req_bus(f_req), .second_req_bus(s_req),
		.first_ind_parity(), .first_ind_control(), .first_ind_data(),
		.first_ind_oe(), .second_ind_parity(), .second_ind_control(),
		.second_ind_data(), .second_ind_oe(s_oe2), .tx_parity(),
		.tx_control(), .tx_data());

	psw_mac_model mac_u (.hclk(hclk), .hresetn(hresetn), .first_ind(f_bus),
		.first_oe(f_oe), .second_ind(s_bus), .second_oe(s_oe),
		.first_req_bus(f_req), .second_req_bus(s_req),
		.first_seen(f_seen), .second_seen(s_seen));

	always #10 hclk = ~hclk;

	// Receiver words and one- and two-cycle-old copies of every source
	always @(posedge hclk) begin
		rx_bus <= rx_bus + 10'h013;
		p[0] <= BUS_INVALID;
		p[1] <= rx_bus;
		p[2] <= f_req;
		p[3] <= s_req;
		q <= p;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic ahb(input logic wr, input logic [11:0] ad,
		input logic [31:0] wd);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {20'h0_0000, ad};
		htrans <= HTRANS_NONSEQ;
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		// Read data taken at the edge that ends the data phase
		rd = hrdata;
		rd2 = hrdata2;
	endtask

	task automatic tally_and_finish();
		$display("checks=%0d errors=%0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	initial begin
		#200000;
		num_errors++;
		tally_and_finish();
	end

	initial begin
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		@(negedge hclk);
		check(f_oe, 1'b0);
		check(s_oe, 1'b0);
		ahb(1'b0, 12'h000, 32'h0000_0000);
		check(rd, {24'h00_0000, CFG_RESET});
		$display("reset test done");
		// Leave active transmit so an invalid source just passes
		ahb(1'b1, 12'h004, 32'h0000_0001);
		ahb(1'b0, 12'h004, 32'h0000_0000);
		check(rd, 32'h0000_0001);
		old = CFG_RESET;
		for (int i = 0; i < 8; i++) begin
			a = i[1:0];
			b = a + 2'h1;
			c = a + 2'h2;
			cfg = {i[2], ~i[2] | i[0], c, b, a};
			ahb(1'b1, 12'h000, {24'h00_0000, cfg});
			@(negedge hclk);
			check(f_oe, old[6]);
			check(s_oe, old[7]);
			for (int k = 0; k < 3; k++) begin
				@(negedge hclk);
				check(f_oe, cfg[6]);
				check(s_oe, cfg[7]);
				check(s_oe2, 1'b0);
				if (cfg[6]) check(f_seen, p[a]);
				if (cfg[7]) check(s_seen, p[b]);
				if (k > 0) check(t_bus, q[c]);
			end
			ahb(1'b0, 12'h000, 32'h0000_0000);
			check(rd, {24'h00_0000, cfg});
			check(rd2, {24'h00_0000, cfg});
			old = cfg;
		end
		$display("routing test done");
		ahb(1'b1, 12'h00c, 32'hffff_ffff);
		ahb(1'b0, 12'h00c, 32'h0000_0000);
		check(rd, 32'h0000_0000);
		ahb(1'b0, 12'h000, 32'h0000_0000);
		check(rd, {24'h00_0000, old});
		$display("unmapped test done");
		ahb(1'b1, 12'h000, 32'h0000_0000);
		ahb(1'b1, 12'h004, 32'h0000_0000);
		@(negedge hclk);
		n = 0;
		while (t_bus !== BUS_HALT_PAIR && n < 20) begin
			@(negedge hclk);
			n++;
		end
		check(t_bus, BUS_HALT_PAIR);
		check(f_oe, 1'b0);
		check(s_oe, 1'b0);
		n = 0;
		while (t_bus === BUS_HALT_PAIR && n < 40) begin
			@(negedge hclk);
			n++;
		end
		check(n, MAXH);
		repeat (4) begin
			check(t_bus, BUS_IDLE_PAIR);
			@(negedge hclk);
		end
		// Status: guard idle, halt count stopped at its last pair
		ahb(1'b0, 12'h008, 32'h0000_0000);
		check(rd, (32'(MAXH - 1) << STAT_COUNT_LSB) | (32'h0000_0001 << STAT_SECOND_BIT) | 32'(GRD_IDLE));
		check(rd2, (32'(MAXH - 1) << STAT_COUNT_LSB) | 32'(GRD_IDLE));
		$display("transmit guard test done");
		tally_and_finish();
	end
endmodule // tb

`default_nettype wire

// ==== verilog/psw_bus_mux.sv ====
// Registered four-way selector for one switch bus
`default_nettype none

module psw_bus_mux
	import psw_pkg::*;
(
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Selection
	input wire logic [1:0] sel,
	// Source buses
	input wire logic [PSW_BUS_W-1:0] rx_bus,
	input wire logic [PSW_BUS_W-1:0] first_req_bus,
	input wire logic [PSW_BUS_W-1:0] second_req_bus,
	// Selected bus
	output logic [PSW_BUS_W-1:0] bus_out_ff
);

	logic [PSW_BUS_W-1:0] nxt_bus_out;

	always_comb begin
		case (sel)
			SEL_RECEIVER: nxt_bus_out = rx_bus;
			SEL_REQ_FIRST: nxt_bus_out = first_req_bus;
			SEL_REQ_SECOND: nxt_bus_out = second_req_bus;
			default: nxt_bus_out = BUS_INVALID;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bus_out_ff <= BUS_INVALID;
		end else begin
			bus_out_ff <= nxt_bus_out;
		end
	end

endmodule // psw_bus_mux

`default_nettype wire

// ==== verilog/psw_pkg.sv ====
// Shared constants and types for the PHY configuration switch block
`default_nettype none

package psw_pkg;

	// Internal switch bus layout: {parity, control, data[7:0]}
	localparam int PSW_DATA_W = 8;
	localparam int PSW_BUS_W = 10;
	localparam int PSW_BUS_PAR_BIT = 9;
	localparam int PSW_BUS_CTL_BIT = 8;

	// Selector encodings shared by all three selectors
	localparam logic [1:0] SEL_INVALID = 2'h0;
	localparam logic [1:0] SEL_RECEIVER = 2'h1;
	localparam logic [1:0] SEL_REQ_FIRST = 2'h2;
	localparam logic [1:0] SEL_REQ_SECOND = 2'h3;

	// switch_config field layout
	localparam int CFG_W = 8;
	localparam int FIRST_SEL_LSB = 0;
	localparam int SECOND_SEL_LSB = 2;
	localparam int TX_SEL_LSB = 4;
	localparam int FIRST_EN_BIT = 6;
	localparam int SECOND_EN_BIT = 7;
	localparam logic [CFG_W-1:0] CFG_RESET = 8'h00;

	// Transmit mode field
	localparam int TM_W = 2;
	localparam logic [TM_W-1:0] TM_ACTIVE = 2'h0;
	localparam logic [TM_W-1:0] TM_RESET = 2'h0;

	// Register byte addresses (low address bits decoded)
	localparam int ADDR_W = 12;
	localparam logic [ADDR_W-1:0] ADDR_SWITCH_CONFIG = 12'h000;
	localparam logic [ADDR_W-1:0] ADDR_TX_MODE = 12'h004;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h008;

	// Status register layout
	localparam int STAT_STATE_LSB = 0;
	localparam int STAT_SECOND_BIT = 2;
	localparam int STAT_COUNT_LSB = 8;

	// Bus words carried by the fixed sources
	localparam logic [PSW_BUS_W-1:0] BUS_INVALID = 10'h100;
	localparam logic [PSW_BUS_W-1:0] BUS_HALT_PAIR = 10'h111;
	localparam logic [PSW_BUS_W-1:0] BUS_IDLE_PAIR = 10'h3ff;

	// AHB-Lite encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic HRESP_OKAY = 1'b0;
	localparam int HDATA_W = 32;

	// Transmit guard default halt pair limit
	localparam int MAX_HALT_PAIRS_DEF = 8;
	localparam int CNT_W = 8;

	typedef enum logic [1:0] {
		GRD_PASS,
		GRD_HALT,
		GRD_IDLE
	} psw_grd_state_t;

endpackage

`default_nettype wire

// ==== verilog/psw_switch_top.sv ====
// Configuration switch register bank with AHB-Lite slave and bus routing
//
// The placing of the registers and the AHB-Lite interface to the registers were chosen for this implementation.
`default_nettype none

module psw_switch_top
	import psw_pkg::*;
#(
	parameter bit HAS_SECOND_IND = 1'b1,
	parameter int MAX_HALT_PAIRS = MAX_HALT_PAIRS_DEF
)
(
	// AHB-Lite clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [HDATA_W-1:0] hwdata,
	output logic hreadyout,
	output logic hresp,
	output logic [HDATA_W-1:0] hrdata,
	// Internal source buses
	input wire logic [PSW_BUS_W-1:0] rx_bus,
	input wire logic [PSW_BUS_W-1:0] first_req_bus,
	input wire logic [PSW_BUS_W-1:0] second_req_bus,
	// First indicate port
	output logic first_ind_parity,
	output logic first_ind_control,
	output logic [PSW_DATA_W-1:0] first_ind_data,
	output logic first_ind_oe,
	// Second indicate port
	output logic second_ind_parity,
	output logic second_ind_control,
	output logic [PSW_DATA_W-1:0] second_ind_data,
	output logic second_ind_oe,
	// Transmitter input
	output logic tx_parity,
	output logic tx_control,
	output logic [PSW_DATA_W-1:0] tx_data
);

	typedef enum logic [1:0] {
		REG_NONE,
		REG_CFG,
		REG_TM,
		REG_STAT
	} psw_reg_t;

	// Address decode, used for both reads and writes
	function automatic psw_reg_t reg_decode(input logic [ADDR_W-1:0] a);
		psw_reg_t r;
		r = REG_NONE;
		if (a == ADDR_SWITCH_CONFIG) begin
			r = REG_CFG;
		end else if (a == ADDR_TX_MODE) begin
			r = REG_TM;
		end else if (a == ADDR_STATUS) begin
			r = REG_STAT;
		end
		return r;
	endfunction

	logic bus_take;
	logic wr_pend_ff;
	logic [ADDR_W-1:0] addr_ff;
	logic [HDATA_W-1:0] hrdata_ff;
	logic [CFG_W-1:0] switch_config_ff;
	logic [CFG_W-1:0] nxt_switch_config;
	logic [TM_W-1:0] transmit_mode_field_ff;
	logic [TM_W-1:0] nxt_transmit_mode_field;
	logic [HDATA_W-1:0] rd_value;
	logic [PSW_BUS_W-1:0] first_bus_ff;
	logic [PSW_BUS_W-1:0] second_bus_ff;
	logic [PSW_BUS_W-1:0] tx_sel_bus_ff;
	logic [PSW_BUS_W-1:0] tx_bus_ff;
	logic first_oe_ff;
	logic second_oe_ff;
	psw_grd_state_t grd_state;
	logic [CNT_W-1:0] grd_count;
	logic cfg_write;

	// Address phase accepted
	assign bus_take = hsel && (htrans == HTRANS_NONSEQ) && hready;
	assign cfg_write = wr_pend_ff && (reg_decode(addr_ff) == REG_CFG);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_ff <= 1'b0;
			addr_ff <= '0;
		end else if (bus_take) begin
			wr_pend_ff <= hwrite;
			addr_ff <= haddr[ADDR_W-1:0];
		end else begin
			wr_pend_ff <= 1'b0;
		end
	end

	// Pending write data lands in the data phase
	always_comb begin
		nxt_switch_config = switch_config_ff;
		nxt_transmit_mode_field = transmit_mode_field_ff;
		if (cfg_write) begin
			nxt_switch_config = hwdata[CFG_W-1:0];
		end else if (wr_pend_ff && reg_decode(addr_ff) == REG_TM) begin
			nxt_transmit_mode_field = hwdata[TM_W-1:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			switch_config_ff <= CFG_RESET;
		end else begin
			switch_config_ff <= nxt_switch_config;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			transmit_mode_field_ff <= TM_RESET;
		end else begin
			transmit_mode_field_ff <= nxt_transmit_mode_field;
		end
	end

	// Read value from next state so back-to-back reads see writes
	always_comb begin
		rd_value = '0;
		case (reg_decode(haddr[ADDR_W-1:0]))
			REG_CFG: rd_value[CFG_W-1:0] = nxt_switch_config;
			REG_TM: rd_value[TM_W-1:0] = nxt_transmit_mode_field;
			REG_STAT: begin
				rd_value[STAT_STATE_LSB +: 2] = grd_state;
				rd_value[STAT_SECOND_BIT] = HAS_SECOND_IND;
				rd_value[STAT_COUNT_LSB +: CNT_W] = grd_count;
			end
			default: rd_value = '0;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_ff <= '0;
		end else if (bus_take && !hwrite) begin
			hrdata_ff <= rd_value;
		end else begin
			hrdata_ff <= '0;
		end
	end

	assign hrdata = hrdata_ff;
	assign hreadyout = 1'b1;
	assign hresp = HRESP_OKAY;

	psw_bus_mux u_first_mux (
		.hclk(hclk),
		.hresetn(hresetn),
		.sel(switch_config_ff[FIRST_SEL_LSB +: 2]),
		.rx_bus(rx_bus),
		.first_req_bus(first_req_bus),
		.second_req_bus(second_req_bus),
		.bus_out_ff(first_bus_ff)
	);

	psw_bus_mux u_second_mux (
		.hclk(hclk),
		.hresetn(hresetn),
		.sel(switch_config_ff[SECOND_SEL_LSB +: 2]),
		.rx_bus(rx_bus),
		.first_req_bus(first_req_bus),
		.second_req_bus(second_req_bus),
		.bus_out_ff(second_bus_ff)
	);

	psw_bus_mux u_tx_mux (
		.hclk(hclk),
		.hresetn(hresetn),
		.sel(switch_config_ff[TX_SEL_LSB +: 2]),
		.rx_bus(rx_bus),
		.first_req_bus(first_req_bus),
		.second_req_bus(second_req_bus),
		.bus_out_ff(tx_sel_bus_ff)
	);

	psw_tx_guard #(
		.MAX_HALT_PAIRS(MAX_HALT_PAIRS)
	) u_tx_guard (
		.hclk(hclk),
		.hresetn(hresetn),
		.tx_mode(transmit_mode_field_ff),
		.tx_sel(switch_config_ff[TX_SEL_LSB +: 2]),
		.bus_in(tx_sel_bus_ff),
		.tx_bus_ff(tx_bus_ff),
		.state_ff(grd_state),
		.count_ff(grd_count)
	);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			first_oe_ff <= 1'b0;
		end else begin
			first_oe_ff <= switch_config_ff[FIRST_EN_BIT];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			second_oe_ff <= 1'b0;
		end else begin
			second_oe_ff <= HAS_SECOND_IND && switch_config_ff[SECOND_EN_BIT];
		end
	end

	assign first_ind_parity = first_bus_ff[PSW_BUS_PAR_BIT];
	assign first_ind_control = first_bus_ff[PSW_BUS_CTL_BIT];
	assign first_ind_data = first_bus_ff[PSW_DATA_W-1:0];
	assign first_ind_oe = first_oe_ff;

	assign second_ind_parity = second_bus_ff[PSW_BUS_PAR_BIT];
	assign second_ind_control = second_bus_ff[PSW_BUS_CTL_BIT];
	assign second_ind_data = second_bus_ff[PSW_DATA_W-1:0];
	assign second_ind_oe = second_oe_ff;

	assign tx_parity = tx_bus_ff[PSW_BUS_PAR_BIT];
	assign tx_control = tx_bus_ff[PSW_BUS_CTL_BIT];
	assign tx_data = tx_bus_ff[PSW_DATA_W-1:0];

	property p_first_route;
		@(posedge hclk) disable iff (!hresetn)
		(switch_config_ff[FIRST_SEL_LSB +: 2] == SEL_RECEIVER) |=>
			({first_ind_parity, first_ind_control, first_ind_data}
			== $past(rx_bus));
	endproperty
	a_first_route: assert property (p_first_route)
		else $error("first indicate port not carrying receiver bus");

	property p_second_route;
		@(posedge hclk) disable iff (!hresetn)
		(switch_config_ff[SECOND_SEL_LSB +: 2] == SEL_REQ_FIRST) |=>
			({second_ind_parity, second_ind_control, second_ind_data}
			== $past(first_req_bus));
	endproperty
	a_second_route: assert property (p_second_route)
		else $error("second indicate port not carrying request bus");

	property p_tx_route;
		@(posedge hclk) disable iff (!hresetn)
		(switch_config_ff[TX_SEL_LSB +: 2] == SEL_REQ_SECOND) |=>
			(tx_sel_bus_ff == $past(second_req_bus));
	endproperty
	a_tx_route: assert property (p_tx_route)
		else $error("transmit source not the second request bus");

	property p_absent_port;
		@(posedge hclk) disable iff (!hresetn)
		!HAS_SECOND_IND |-> !second_ind_oe;
	endproperty
	a_absent_port: assert property (p_absent_port)
		else $error("absent second port is driven");

	property p_idle_after_halt;
		@(posedge hclk) disable iff (!hresetn)
		(grd_state == GRD_IDLE) |=> (tx_bus_ff == BUS_IDLE_PAIR);
	endproperty
	a_idle_after_halt: assert property (p_idle_after_halt)
		else $error("transmitter not fed idle after halt pairs");

	property p_halt_bound;
		@(posedge hclk) disable iff (!hresetn)
		(transmit_mode_field_ff == TM_ACTIVE &&
			switch_config_ff[TX_SEL_LSB +: 2] == SEL_INVALID &&
			grd_state == GRD_HALT) |->
			(grd_count < CNT_W'(MAX_HALT_PAIRS));
	endproperty
	a_halt_bound: assert property (p_halt_bound)
		else $error("halt pair count exceeded");

	property p_first_tristate;
		@(posedge hclk) disable iff (!hresetn)
		!switch_config_ff[FIRST_EN_BIT] |=> !first_ind_oe;
	endproperty
	a_first_tristate: assert property (p_first_tristate)
		else $error("first port driven while disabled");

	property p_second_disable;
		@(posedge hclk) disable iff (!hresetn)
		!switch_config_ff[SECOND_EN_BIT] |=> !second_ind_oe;
	endproperty
	a_second_disable: assert property (p_second_disable)
		else $error("second port driven while disabled");

	property p_write_effect;
		@(posedge hclk) disable iff (!hresetn)
		cfg_write |=> ##1
			(first_ind_oe == $past(hwdata[FIRST_EN_BIT], 2));
	endproperty
	a_write_effect: assert property (p_write_effect)
		else $error("enable write not seen on port in time");

endmodule // psw_switch_top

`default_nettype wire

// ==== verilog/psw_tx_guard.sv ====
// Transmitter input guard: halt pairs then idle on an invalid source in active transmit mode
`default_nettype none

module psw_tx_guard
	import psw_pkg::*;
#(
	parameter int MAX_HALT_PAIRS = MAX_HALT_PAIRS_DEF
)
(
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Control
	input wire logic [TM_W-1:0] tx_mode,
	input wire logic [1:0] tx_sel,
	// Selected transmit source
	input wire logic [PSW_BUS_W-1:0] bus_in,
	// Transmitter input and state
	output logic [PSW_BUS_W-1:0] tx_bus_ff,
	output psw_grd_state_t state_ff,
	output logic [CNT_W-1:0] count_ff
);

	localparam logic [CNT_W-1:0] LAST_PAIR = CNT_W'(MAX_HALT_PAIRS - 1);
	logic hold_line;
	psw_grd_state_t nxt_state;

	assign hold_line = (tx_mode == TM_ACTIVE) && (tx_sel == SEL_INVALID);

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			GRD_PASS: if (hold_line) nxt_state = GRD_HALT;
			GRD_HALT: begin
				if (!hold_line) begin
					nxt_state = GRD_PASS;
				end else if (count_ff == LAST_PAIR) begin
					nxt_state = GRD_IDLE;
				end
			end
			GRD_IDLE: if (!hold_line) nxt_state = GRD_PASS;
			default: nxt_state = GRD_PASS;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_ff <= GRD_PASS;
		end else begin
			state_ff <= nxt_state;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count_ff <= '0;
		end else if (state_ff == GRD_HALT && count_ff != LAST_PAIR) begin
			count_ff <= count_ff + 1'b1;
		end else if (state_ff == GRD_PASS) begin
			count_ff <= '0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_bus_ff <= BUS_INVALID;
		end else begin
			case (state_ff)
				GRD_HALT: tx_bus_ff <= BUS_HALT_PAIR;
				GRD_IDLE: tx_bus_ff <= BUS_IDLE_PAIR;
				default: tx_bus_ff <= bus_in;
			endcase
		end
	end

endmodule // psw_tx_guard

`default_nettype wire
